// ==== ptw_regs.vh ====
// register map, field layout and timing constants of the pulse timing block
`ifndef PTW_REGS_VH
`define PTW_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PTW_ADDR_THR_X      8'h23
`define PTW_ADDR_THR_Y      8'h24
`define PTW_ADDR_THR_Z      8'h25
`define PTW_ADDR_WIDTH_LIM  8'h26
`define PTW_ADDR_IGNORE     8'h27
`define PTW_ADDR_CONFIG     8'h40
`define PTW_ADDR_STATUS     8'h41
`define PTW_ADDR_INT_EN     8'h42
`define PTW_ADDR_INT_CLR    8'h43
`define PTW_ADDR_STATE      8'h44

// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define PTW_RST_BYTE        8'h00
`define PTW_RST_THR         7'h00
`define PTW_RST_CFG         6'h00
`define PTW_THR_W           7
`define PTW_CFG_ODR_LSB     0
`define PTW_CFG_ODR_MSB     2
`define PTW_CFG_MODE_LSB    3
`define PTW_CFG_MODE_MSB    4
`define PTW_CFG_HPF_BIT     5
`define PTW_ST_DETECT_BIT   0
`define PTW_ST_OVER_BIT     1
`define PTW_ST_W            2

// ----------------------------------------------------------------
// data rate codes and power modes
// ----------------------------------------------------------------
`define PTW_ODR_800         3'h0
`define PTW_ODR_400         3'h1
`define PTW_ODR_200         3'h2
`define PTW_ODR_100         3'h3
`define PTW_ODR_50          3'h4
`define PTW_MODE_NORMAL     2'h0
`define PTW_MODE_LOW_POWER_LOW_NOISE_MODE       2'h1
`define PTW_MODE_HIRES      2'h2
`define PTW_MODE_LOWPWR     2'h3

// ----------------------------------------------------------------
// time steps in units of the 0.625 ms base tick
// ----------------------------------------------------------------
`define PTW_BASE_TICK_NS    625000
`define PTW_CLK_PERIOD_NS   4
`define PTW_S0P625          9'h001
`define PTW_S1P25           9'h002
`define PTW_S2P5            9'h004
`define PTW_S5              9'h008
`define PTW_S10             9'h010
`define PTW_S20             9'h020
`define PTW_S40             9'h040
`define PTW_S80             9'h080
`define PTW_S160            9'h100

`endif

// ==== ptw_step_gen.v ====
// time step generator: base tick prescaler and step divider
`timescale 1ns/1ps
module ptw_step_gen #(
	parameter BASE_CYCLES = 156250
) (
	// clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// control
	input  wire       restart,
	input  wire [9:0] mult,
	// step enable
	output reg        step_q
);

reg  [31:0] pre_q;
reg  [9:0]  div_q;
wire        base_tick;
wire [31:0] base_last;

assign base_last = BASE_CYCLES - 1;
assign base_tick = (pre_q == base_last);

// ----------------------------------------------------------------
// prescaler and step divider
// ----------------------------------------------------------------
always @(posedge clk)
begin
	if (sys_rst || restart)
	begin
		pre_q  <= 32'h0;
		div_q  <= 10'h0;
		step_q <= 1'b0;
	end
	else
	begin
		step_q <= 1'b0;
		if (base_tick)
		begin
			pre_q <= 32'h0;
			if (div_q + 10'h1 >= mult)
			begin
				div_q  <= 10'h0;
				step_q <= 1'b1;
			end
			else
				div_q <= div_q + 10'h1;
		end
		else
			pre_q <= pre_q + 32'h1;
	end
end

endmodule // ptw_step_gen

// ==== ptw_top.v ====
// pulse timing windows: pulse width limit and ignore interval
//
// Summary of operation
// - pulse counts only if it ends within limit
// - width step with filter on follows table
// - width step with filter off is a half or a quarter of the filter-on table
// - longest width interval is step times 256
// - after a pulse, ignore new starts for interval
// - ignore step with filter on follows table
// - ignore step with filter off follows table
// - longest ignore interval is step times 255
// - 400 Hz normal, filter off: 0.625 ms step
// - thresholds unsigned 7-bit on fixed 8 g scale
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "ptw_regs.vh"
module ptw_top #(
	parameter BASE_CYCLES = `PTW_BASE_TICK_NS / `PTW_CLK_PERIOD_NS,
	parameter AXES        = 3
) (
	// clock and reset
	input  wire       clk,
	input  wire       sys_rst,
	// register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_q,
	// acceleration samples, signed, fixed 8 g scale
	input  wire       sample_valid,
	input  wire [7:0] accel_x,
	input  wire [7:0] accel_y,
	input  wire [7:0] accel_z,
	// events
	output reg        pulse_q,
	output reg        ignoring_q,
	output reg        irq_q
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [3:0] ST_IDLE   = 4'b0001;
localparam [3:0] ST_HIGH   = 4'b0010;
localparam [3:0] ST_OVER   = 4'b0100;
localparam [3:0] ST_IGNORE = 4'b1000;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [6:0]              thr_x_q;
reg  [6:0]              thr_y_q;
reg  [6:0]              thr_z_q;
reg  [7:0]              width_lim_q;
reg  [7:0]              ignore_q;
reg  [5:0]              cfg_q;
reg  [`PTW_ST_W-1:0]    status_q;
reg  [`PTW_ST_W-1:0]    int_en_q;
reg  [3:0]              state_q;
reg  [3:0]              state_d;
reg  [8:0]              cnt_q;
reg  [8:0]              cnt_d;
reg  [AXES-1:0]         above_q;
reg                     restart_d;
reg                     detect_d;
reg                     over_d;
reg  [8:0]              width_mult;
reg  [9:0]              ignore_mult;
reg  [7:0]              rd_mux;

wire [2:0]              odr;
wire [1:0]              mode;
wire                    hpf_en;
wire [AXES*8-1:0]       accel_all;
wire [AXES*7-1:0]       thr_all;
wire                    any_above;
wire                    width_step;
wire                    ignore_step;
wire [`PTW_ST_W-1:0]    int_clr;
wire [`PTW_ST_W-1:0]    status_d;

assign odr       = cfg_q[`PTW_CFG_ODR_MSB:`PTW_CFG_ODR_LSB];
assign mode      = cfg_q[`PTW_CFG_MODE_MSB:`PTW_CFG_MODE_LSB];
assign hpf_en    = cfg_q[`PTW_CFG_HPF_BIT];
assign accel_all = {accel_z, accel_y, accel_x};
assign thr_all   = {thr_z_q, thr_y_q, thr_x_q};
assign any_above = |above_q;

// ----------------------------------------------------------------
// threshold compare per axis
// ----------------------------------------------------------------
genvar g;
generate
	for (g = 0; g < AXES; g = g + 1)
	begin : g_axis
		wire [7:0] a;
		wire [7:0] mag;
		assign a   = accel_all[g*8 +: 8];
		assign mag = a[7] ? (8'h00 - a) : a;
		always @(posedge clk)
		begin
			if (sys_rst)
				above_q[g] <= 1'b0;
			else if (sample_valid)
				above_q[g] <= (mag > {1'b0, thr_all[g*7 +: 7]});
		end
	end
endgenerate

// ----------------------------------------------------------------
// width limit step, filter on and off
// ----------------------------------------------------------------
always @*
begin
	width_mult = `PTW_S20;
	if (hpf_en)
	begin
		case (odr)
		`PTW_ODR_800: width_mult = `PTW_S1P25;
		`PTW_ODR_400: width_mult = `PTW_S2P5;
		`PTW_ODR_200: width_mult = (mode == `PTW_MODE_HIRES) ?
			`PTW_S2P5 : `PTW_S5;
		`PTW_ODR_100: width_mult = (mode == `PTW_MODE_HIRES) ?
			`PTW_S2P5 : `PTW_S10;
		`PTW_ODR_50: width_mult = (mode == `PTW_MODE_HIRES) ?
			`PTW_S2P5 : `PTW_S20;
		`PTW_ODR_50 + 3'h1:
			case (mode)
			`PTW_MODE_NORMAL: width_mult = `PTW_S20;
			`PTW_MODE_HIRES:  width_mult = `PTW_S2P5;
			default:          width_mult = `PTW_S80;
			endcase
		default:
			case (mode)
			`PTW_MODE_NORMAL: width_mult = `PTW_S20;
			`PTW_MODE_LOW_POWER_LOW_NOISE_MODE:   width_mult = `PTW_S80;
			`PTW_MODE_HIRES:  width_mult = `PTW_S2P5;
			default:          width_mult = `PTW_S160;
			endcase
		endcase
	end
	else
	begin
		case (odr)
		`PTW_ODR_800: width_mult = `PTW_S0P625;
		`PTW_ODR_400: width_mult = (mode == `PTW_MODE_LOWPWR) ?
			`PTW_S1P25 : `PTW_S0P625;
		`PTW_ODR_200:
			case (mode)
			`PTW_MODE_HIRES:  width_mult = `PTW_S0P625;
			`PTW_MODE_LOWPWR: width_mult = `PTW_S2P5;
			default:          width_mult = `PTW_S1P25;
			endcase
		`PTW_ODR_100:
			case (mode)
			`PTW_MODE_HIRES:  width_mult = `PTW_S0P625;
			`PTW_MODE_LOWPWR: width_mult = `PTW_S5;
			default:          width_mult = `PTW_S2P5;
			endcase
		`PTW_ODR_50:
			case (mode)
			`PTW_MODE_HIRES:  width_mult = `PTW_S0P625;
			`PTW_MODE_LOWPWR: width_mult = `PTW_S10;
			default:          width_mult = `PTW_S5;
			endcase
		default:
			case (mode)
			`PTW_MODE_NORMAL: width_mult = `PTW_S5;
			`PTW_MODE_LOW_POWER_LOW_NOISE_MODE:   width_mult = `PTW_S20;
			`PTW_MODE_HIRES:  width_mult = `PTW_S0P625;
			default:          width_mult = `PTW_S40;
			endcase
		endcase
	end
end

// ----------------------------------------------------------------
// ignore interval step
// ----------------------------------------------------------------
always @*
begin
	ignore_mult = {width_mult, 1'b0};
	if (hpf_en)
		ignore_mult = {width_mult, 1'b0};
	else
	begin
		case (odr)
		`PTW_ODR_800: ignore_mult = {1'b0, `PTW_S1P25};
		`PTW_ODR_400: ignore_mult = (mode == `PTW_MODE_LOWPWR) ?
			{1'b0, `PTW_S2P5} : {1'b0, `PTW_S1P25};
		default:      ignore_mult = {width_mult, 1'b0};
		endcase
	end
end

// ----------------------------------------------------------------
// step generators
// ----------------------------------------------------------------
ptw_step_gen #(
	.BASE_CYCLES (BASE_CYCLES)
) u_width_step (
	.clk     (clk),
	.sys_rst (sys_rst),
	.restart (restart_d),
	.mult    ({1'b0, width_mult}),
	.step_q  (width_step)
);

ptw_step_gen #(
	.BASE_CYCLES (BASE_CYCLES)
) u_ignore_step (
	.clk     (clk),
	.sys_rst (sys_rst),
	.restart (restart_d),
	.mult    (ignore_mult),
	.step_q  (ignore_step)
);

// ----------------------------------------------------------------
// pulse timing state machine
// ----------------------------------------------------------------
always @*
begin
	state_d   = state_q;
	cnt_d     = cnt_q;
	restart_d = 1'b0;
	detect_d  = 1'b0;
	over_d    = 1'b0;
	case (state_q)
	ST_IDLE:
		if (any_above)
		begin
			state_d   = ST_HIGH;
			cnt_d     = 9'h000;
			restart_d = 1'b1;
		end
	ST_HIGH:
		if (!any_above)
		begin
			state_d   = ST_IGNORE;
			detect_d  = 1'b1;
			cnt_d     = 9'h000;
			restart_d = 1'b1;
		end
		else if (width_step)
		begin
			cnt_d = cnt_q + 9'h001;
			if (cnt_d > {1'b0, width_lim_q})
			begin
				state_d = ST_OVER;
				over_d  = 1'b1;
			end
		end
	ST_OVER:
		if (!any_above)
			state_d = ST_IDLE;
	ST_IGNORE:
		if (cnt_q >= {1'b0, ignore_q})
			state_d = ST_IDLE;
		else if (ignore_step)
			cnt_d = cnt_q + 9'h001;
	default:
		state_d = ST_IDLE;
	endcase
end

always @(posedge clk)
begin
	if (sys_rst)
	begin
		state_q    <= ST_IDLE;
		cnt_q      <= 9'h000;
		pulse_q    <= 1'b0;
		ignoring_q <= 1'b0;
	end
	else
	begin
		state_q    <= state_d;
		cnt_q      <= cnt_d;
		pulse_q    <= detect_d;
		ignoring_q <= (state_d == ST_IGNORE);
	end
end

// ----------------------------------------------------------------
// status, enable and interrupt
// ----------------------------------------------------------------
assign int_clr  = (reg_wr && reg_addr == `PTW_ADDR_INT_CLR) ?
	reg_wdata[`PTW_ST_W-1:0] : {`PTW_ST_W{1'b0}};
assign status_d = (status_q & ~int_clr) | {over_d, detect_d};

always @(posedge clk)
begin
	if (sys_rst)
	begin
		status_q <= {`PTW_ST_W{1'b0}};
		irq_q    <= 1'b0;
	end
	else
	begin
		status_q <= status_d;
		irq_q    <= |(status_d & int_en_q);
	end
end

// ----------------------------------------------------------------
// register writes
// ----------------------------------------------------------------
always @(posedge clk)
begin
	if (sys_rst)
	begin
		thr_x_q     <= `PTW_RST_THR;
		thr_y_q     <= `PTW_RST_THR;
		thr_z_q     <= `PTW_RST_THR;
		width_lim_q <= `PTW_RST_BYTE;
		ignore_q    <= `PTW_RST_BYTE;
		cfg_q       <= `PTW_RST_CFG;
		int_en_q    <= {`PTW_ST_W{1'b0}};
	end
	else if (reg_wr)
	begin
		case (reg_addr)
		`PTW_ADDR_THR_X:     thr_x_q     <= reg_wdata[6:0];
		`PTW_ADDR_THR_Y:     thr_y_q     <= reg_wdata[6:0];
		`PTW_ADDR_THR_Z:     thr_z_q     <= reg_wdata[6:0];
		`PTW_ADDR_WIDTH_LIM: width_lim_q <= reg_wdata;
		`PTW_ADDR_IGNORE:    ignore_q    <= reg_wdata;
		`PTW_ADDR_CONFIG:    cfg_q       <= reg_wdata[5:0];
		`PTW_ADDR_INT_EN:    int_en_q    <= reg_wdata[`PTW_ST_W-1:0];
		default:             ;
		endcase
	end
end

// ----------------------------------------------------------------
// register reads
// ----------------------------------------------------------------
always @*
begin
	case (reg_addr)
	`PTW_ADDR_THR_X:     rd_mux = {1'b0, thr_x_q};
	`PTW_ADDR_THR_Y:     rd_mux = {1'b0, thr_y_q};
	`PTW_ADDR_THR_Z:     rd_mux = {1'b0, thr_z_q};
	`PTW_ADDR_WIDTH_LIM: rd_mux = width_lim_q;
	`PTW_ADDR_IGNORE:    rd_mux = ignore_q;
	`PTW_ADDR_CONFIG:    rd_mux = {2'b00, cfg_q};
	`PTW_ADDR_STATUS:    rd_mux = {6'h00, status_q};
	`PTW_ADDR_INT_EN:    rd_mux = {6'h00, int_en_q};
	`PTW_ADDR_STATE:     rd_mux = {1'b0, above_q, state_q};
	default:             rd_mux = `PTW_RST_BYTE;
	endcase
end

always @(posedge clk)
begin
	if (sys_rst)
		reg_rdata_q <= `PTW_RST_BYTE;
	else if (reg_rd)
		reg_rdata_q <= rd_mux;
	else
		reg_rdata_q <= `PTW_RST_BYTE;
end

endmodule // ptw_top

// ==== ptw_checker.sv ====
// port assertions of the pulse timing block
`timescale 1ns/1ps
module ptw_checker #(
	parameter BASE_CYCLES = 4,
	parameter AXES        = 3
) (
	// clock and reset
	input logic       clk,
	input logic       sys_rst,
	// register port
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_wr,
	input logic       reg_rd,
	input logic [7:0] reg_rdata_q,
	// samples
	input logic       sample_valid,
	input logic [7:0] accel_x,
	input logic [7:0] accel_y,
	input logic [7:0] accel_z,
	// events
	input logic       pulse_q,
	input logic       ignoring_q,
	input logic       irq_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ------
	// properties
	// ------
	sequence s_wr_lim;
		reg_wr && reg_addr == 8'h26;
	endsequence
	sequence s_rd_lim;
		reg_rd && reg_addr == 8'h26;
	endsequence
	property p_lim_back;
		s_wr_lim ##1 !reg_wr ##1 s_rd_lim |=>
			reg_rdata_q == $past(reg_wdata, 3);
	endproperty
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata_q == 8'h00;
	endproperty
	property p_unmapped;
		reg_rd && reg_addr > 8'h44 |=> reg_rdata_q == 8'h00;
	endproperty
	property p_pulse_once;
		pulse_q |=> !pulse_q;
	endproperty
	property p_pulse_ign;
		pulse_q |-> ignoring_q;
	endproperty
	property p_ign_start;
		$rose(ignoring_q) |-> pulse_q;
	endproperty
	property p_ign_block;
		ignoring_q && $past(ignoring_q) |-> !pulse_q;
	endproperty
	property p_pulse_cause;
		pulse_q |-> $past(sample_valid, 2);
	endproperty
	property p_irq_fall;
		$fell(irq_q) |->
			($past(reg_wr) && $past(reg_addr) == 8'h43) ||
			($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h42);
	endproperty
	a_lim_back: assert property (p_lim_back)
		else $error("width limit readback wrong");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_pulse_once: assert property (p_pulse_once)
		else $error("pulse longer than one cycle");
	a_pulse_ign: assert property (p_pulse_ign)
		else $error("no ignore after pulse");
	a_ign_start: assert property (p_ign_start)
		else $error("ignore without pulse");
	a_ign_block: assert property (p_ign_block)
		else $error("pulse while ignoring");
	a_pulse_cause: assert property (p_pulse_cause)
		else $error("pulse without falling sample");
	a_irq_fall: assert property (p_irq_fall)
		else $error("irq dropped without write");
endmodule // ptw_checker

bind ptw_top ptw_checker #(.BASE_CYCLES(BASE_CYCLES), .AXES(AXES)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .sample_valid(sample_valid),
	.accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
	.pulse_q(pulse_q), .ignoring_q(ignoring_q), .irq_q(irq_q));

// ==== ptw_top_tb.sv ====
// self-checking testbench of the pulse timing block
`timescale 1ns/1ps
module ptw_top_tb;
	logic       clk = 0;
	logic       sys_rst = 1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 0;
	logic       reg_rd = 0;
	logic [7:0] reg_rdata_q;
	logic       sample_valid = 0;
	logic [7:0] accel_x = 8'h00;
	logic [7:0] accel_y = 8'h00;
	logic [7:0] accel_z = 8'h00;
	logic       pulse_q;
	logic       ignoring_q;
	logic       irq_q;
	int         failures = 0;
	int         comparisons = 0;
	int         cyc = 0;
	// config byte, width step and ignore step in base ticks
	logic [7:0] cfg_t [11] = '{8'h00, 8'h01, 8'h19, 8'h20, 8'h21, 8'h34,
		8'h24, 8'h3f, 8'h1f, 8'h2d, 8'h0e};
	int         ws_t [11] = '{1, 1, 2, 2, 4, 4, 32, 256, 64, 128, 32};
	int         is_t [11] = '{2, 2, 4, 4, 8, 8, 64, 512, 128, 256, 64};

	always #2 clk = ~clk;

	ptw_top #(.BASE_CYCLES(4), .AXES(3)) dut (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .sample_valid(sample_valid),
		.accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
		.pulse_q(pulse_q), .ignoring_q(ignoring_q), .irq_q(irq_q));
	// ------
	// shared tasks
	// ------
	task summarize;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata_q}, {8'h00, e});
	endtask
	task smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		@(posedge clk);
		sample_valid <= 1'b1;
		accel_x      <= x;
		accel_y      <= y;
		accel_z      <= z;
		@(posedge clk);
		sample_valid <= 1'b0;
	endtask
	task irq(input logic e);
		@(posedge clk);
		#1;
		chk(16'(irq_q), 16'(e));
	endtask
	// excursion held hold clocks; lo is the expected ignore length
	task run(input int hold, input logic ep, input int lo);
		logic got;
		int   len;
		got = 0;
		len = 0;
		@(posedge clk);
		sample_valid <= 1'b1;
		accel_x      <= 8'he0;
		@(posedge clk);
		sample_valid <= 1'b0;
		repeat (hold) @(posedge clk);
		sample_valid <= 1'b1;
		accel_x      <= 8'h00;
		@(posedge clk);
		sample_valid <= 1'b0;
		repeat (4)
		begin
			@(posedge clk);
			#1;
			if (pulse_q === 1'b1)
			begin
				got = 1;
				while (ignoring_q === 1'b1 && len < 5000)
				begin
					@(posedge clk);
					#1;
					len++;
				end
			end
		end
		chk(16'(got), 16'(ep));
		if (ep)
			chk(16'(len >= lo - 2 && len <= lo + 6), 16'h0001);
	endtask
	// ------
	// scenarios
	// ------
	task t_regs;
		rdc(8'h26, 8'h00);
		rdc(8'h27, 8'h00);
		wr(8'h26, 8'hff);
		rdc(8'h26, 8'hff);
		wr(8'h27, 8'h5a);
		rdc(8'h27, 8'h5a);
		wr(8'h23, 8'h90);
		rdc(8'h23, 8'h10);
		wr(8'h41, 8'hff);
		rdc(8'h41, 8'h00);
		rdc(8'h43, 8'h00);
		rdc(8'h50, 8'h00);
		rdc(8'h44, 8'h01);
		wr(8'h40, 8'hff);
		rdc(8'h40, 8'h3f);
		wr(8'h42, 8'h03);
		rdc(8'h42, 8'h03);
		wr(8'h42, 8'h00);
		$display("test regs done");
	endtask
	task t_cfg;
		for (int i = 0; i < 11; i++)
		begin
			wr(8'h40, cfg_t[i]);
			wr(8'h26, 8'h02);
			wr(8'h27, 8'h02);
			run(ws_t[i] * 4, 1'b1, is_t[i] * 8);
			run(ws_t[i] * 16, 1'b0, 0);
		end
		$display("test steps done");
	endtask
	task t_max;
		wr(8'h40, 8'h00);
		wr(8'h26, 8'hff);
		wr(8'h27, 8'hff);
		run(1000, 1'b1, 2040);
		run(1040, 1'b0, 0);
		$display("test max done");
	endtask
	task t_irq;
		wr(8'h26, 8'h02);
		wr(8'h27, 8'h02);
		wr(8'h43, 8'h03);
		wr(8'h42, 8'h01);
		rdc(8'h41, 8'h00);
		run(4, 1'b1, 16);
		irq(1'b1);
		rdc(8'h41, 8'h01);
		wr(8'h43, 8'h01);
		irq(1'b0);
		run(16, 1'b0, 0);
		rdc(8'h41, 8'h02);
		irq(1'b0);
		wr(8'h42, 8'h02);
		irq(1'b1);
		wr(8'h43, 8'h02);
		irq(1'b0);
		$display("test irq done");
	endtask
	task t_axes;
		wr(8'h24, 8'h05);
		wr(8'h25, 8'h7f);
		smp(8'h00, 8'h00, 8'h81);
		rdc(8'h44, 8'h01);
		smp(8'h00, 8'h00, 8'h80);
		rdc(8'h44, 8'h42);
		smp(8'h00, 8'h00, 8'h00);
		rdc(8'h44, 8'h08);
		smp(8'h00, 8'hfa, 8'h00);
		rdc(8'h44, 8'h28);
		smp(8'h00, 8'h00, 8'h00);
		repeat (30) @(posedge clk);
		rdc(8'h44, 8'h01);
		$display("test axes done");
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			failures++;
			summarize;
		end
	end

	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs;
		t_cfg;
		t_max;
		t_irq;
		t_axes;
		summarize;
	end
endmodule // ptw_top_tb
